/* rtl/iosm_top.sv */
// i/o status and maintenance monitor, apb slave
// assumes pins are asynchronous, drive-side signals share pclk
`include "iosm_consts.svh"

module iosm_top #(
   parameter int unsigned SEC_CYCLES = `IOSM_SEC_NS / `IOSM_CLK_NS, // cycles per second
   parameter logic [11:0] HOUR_SECS = 12'(`IOSM_HOUR_S) // seconds per hour
) (
   input wire logic pclk, // system clock, 100 mhz
   input wire logic presetn, // async reset, active low
   input wire logic ce, // clock enable, freezes all state
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction, high writes
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error, unmapped address
   input wire logic forward_run_input, // terminal pin
   input wire logic reverse_run_input, // terminal pin
   input wire logic general_input_1, // terminal pin
   input wire logic general_input_2, // terminal pin
   input wire logic general_input_3, // terminal pin
   input wire logic source_input_common, // jumper pin, high selects source
   input wire logic link_forward_command, // from link logic
   input wire logic link_reverse_command, // from link logic
   input wire logic link_reset_command, // from link logic
   input wire logic transistor_output, // high while conducting
   input wire logic relay_contact_output, // high when open contact closed
   input wire logic meas_valid, // pulse: measurements fresh
   input wire logic [15:0] heat_sink_temp, // degrees celsius
   input wire logic [15:0] eff_current, // amperes
   input wire logic [15:0] dc_link_volts, // volts
   input wire logic [15:0] cap_meas, // present capacitance
   input wire logic cap_voltage_on, // level: capacitors powered
   output logic view_active, // maintenance views offered
   output logic [3:0] led_digit3, // leftmost hex digit
   output logic [3:0] led_digit2, // hex digit
   output logic [3:0] led_digit1, // hex digit
   output logic [3:0] led_digit0 // rightmost hex digit
);

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   localparam logic [31:0] SEC_LAST = 32'(SEC_CYCLES - 1);
   localparam logic [15:0] CAP_STEP_LAST = 16'(`IOSM_CAP_STEP_H * HOUR_SECS - 1);

   logic [5:0] pin_s1_q, pin_s2_q;
   logic comm_q;
   logic [1:0] scope_q;
   iosm_pkg::iosm_view_t view_q;
   logic [4:0] inv_q;
   logic [15:0] cap_ref_q;
   logic [4:0] term_on, term_shown;
   iosm_pkg::iosm_word_t in_status_q, out_status_q;
   logic [31:0] sec_cnt_q;
   logic [11:0] hour_sec_q;
   logic sec_tick, hour_tick;
   logic [15:0] hours_q;
   logic [16:0] hours_shown;
   logic [15:0] cap_sec_q, cap_hours_q;
   logic cap_on_q;
   logic [15:0] dcv_q, cap_pct_q;
   iosm_pkg::iosm_word_t heat_peak, curr_peak, disp_word;
   logic [31:0] rd_d;
   logic hit_d, wr_en, ans_q;

   // shows the hour count at the resolution its range allows
   function automatic logic [16:0] hrs_disp(input logic [15:0] cnt);
      logic [15:0] tens;
      tens = cnt / `IOSM_HRS_DIV;
      if (cnt < `IOSM_HRS_FINE_LIMIT) begin
         hrs_disp = {1'b0, cnt};
      end else begin
         hrs_disp = {1'b1, tens};
      end
   endfunction : hrs_disp

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   // terminal pins are asynchronous to pclk, so two stages each
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1_q <= 6'h00;
         pin_s2_q <= 6'h00;
      end else if (ce) begin
         pin_s1_q <= {source_input_common, general_input_3, general_input_2,
                      general_input_1, reverse_run_input, forward_run_input};
         pin_s2_q <= pin_s1_q;
      end
   end

   // sink wiring pulls a closed terminal low, source wiring pulls it high
   assign term_on = pin_s2_q[5] ? pin_s2_q[4:0] : ~pin_s2_q[4:0];
   // link-sourced display ignores the terminal inversion mask
   assign term_shown = comm_q ? term_on : term_on ^ inv_q;

   // ----------------------------------------
   // status words
   // ----------------------------------------
   // both words load in the same cycle so no word mixes two instants
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_status_q <= 16'h0000;
         out_status_q <= 16'h0000;
      end else if (ce) begin
         in_status_q <= {comm_q & link_reset_command,
                         comm_q & link_reverse_command,
                         comm_q & link_forward_command,
                         8'h00,
                         term_shown};
         out_status_q <= {7'h00, relay_contact_output,
                          7'h00, transistor_output};
      end
   end

   // ----------------------------------------
   // time base
   // ----------------------------------------
   assign sec_tick = sec_cnt_q == SEC_LAST;
   assign hour_tick = sec_tick && hour_sec_q == HOUR_SECS - 12'h001;

   // one-second prescaler, then seconds within the hour
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sec_cnt_q <= 32'h0000_0000;
         hour_sec_q <= 12'h000;
      end else if (ce) begin
         sec_cnt_q <= sec_tick ? 32'h0000_0000 : sec_cnt_q + 32'h0000_0001;
         if (hour_tick) begin
            hour_sec_q <= 12'h000;
         end else if (sec_tick) begin
            hour_sec_q <= hour_sec_q + 12'h001;
         end
      end
   end

   // ----------------------------------------
   // power-on hours
   // ----------------------------------------
   // plain 16-bit add gives the wrap from 65535 to zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hours_q <= 16'h0000;
      end else if (ce && hour_tick) begin
         hours_q <= hours_q + 16'h0001;
      end
   end

   assign hours_shown = hrs_disp(hours_q);

   // ----------------------------------------
   // capacitor powered time
   // ----------------------------------------
   // seconds count only while the capacitors see voltage; the level is
   // sampled once so a mid-second change cannot split a count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap_on_q <= 1'b0;
         cap_sec_q <= 16'h0000;
         cap_hours_q <= 16'h0000;
      end else if (ce) begin
         cap_on_q <= cap_voltage_on;
         if (sec_tick && cap_on_q) begin
            if (cap_sec_q == CAP_STEP_LAST) begin
               cap_sec_q <= 16'h0000;
               if (cap_hours_q != `IOSM_CAP_SAT) begin
                  cap_hours_q <= cap_hours_q + 16'h0001;
               end
            end else begin
               cap_sec_q <= cap_sec_q + 16'h0001;
            end
         end
      end
   end

   // ----------------------------------------
   // measurements
   // ----------------------------------------
   // the divide is wide but only runs on a fresh sample; a zero
   // shipment value would be meaningless, so it shows zero percent
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dcv_q <= 16'h0000;
         cap_pct_q <= 16'h0000;
      end else if (ce && meas_valid) begin
         dcv_q <= dc_link_volts;
         if (cap_ref_q == 16'h0000) begin
            cap_pct_q <= 16'h0000;
         end else begin
            cap_pct_q <= 16'(({16'h0000, cap_meas} * `IOSM_PCT_FULL)
                             / {16'h0000, cap_ref_q});
         end
      end
   end

   iosm_peak_hold u_heat_peak (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .hour_start(hour_tick),
      .sample_valid(meas_valid),
      .sample(heat_sink_temp),
      .peak(heat_peak)
   );

   iosm_peak_hold u_curr_peak (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .hour_start(hour_tick),
      .sample_valid(meas_valid),
      .sample(eff_current),
      .peak(curr_peak)
   );

   // ----------------------------------------
   // display
   // ----------------------------------------
   assign view_active = scope_q == `IOSM_SCOPE_FULL;

   // outside full-menu scope nothing is shown
   always_comb begin
      disp_word = 16'h0000;
      if (view_active) begin
         unique case (view_q)
            iosm_pkg::VIEW_IN: disp_word = in_status_q;
            iosm_pkg::VIEW_OUT: disp_word = out_status_q;
            iosm_pkg::VIEW_HRS: disp_word = hours_shown[15:0];
            iosm_pkg::VIEW_DCV: disp_word = dcv_q;
            iosm_pkg::VIEW_HEAT: disp_word = heat_peak;
            iosm_pkg::VIEW_CURR: disp_word = curr_peak;
            iosm_pkg::VIEW_CAPPCT: disp_word = cap_pct_q;
            iosm_pkg::VIEW_CAPHRS: disp_word = cap_hours_q;
         endcase
      end
   end

   iosm_hex_digits u_digits (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .word(disp_word),
      .digit3(led_digit3),
      .digit2(led_digit2),
      .digit1(led_digit1),
      .digit0(led_digit0)
   );

   // ----------------------------------------
   // apb slave
   // ----------------------------------------
   // access ends in the first running cycle after the answer is captured
   assign pready = ce && ans_q;
   assign wr_en = psel && penable && pwrite && pready;

   // software-owned control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         comm_q <= 1'(`IOSM_CTRL_RESET);
         scope_q <= 2'h0;
         view_q <= iosm_pkg::VIEW_IN;
         inv_q <= `IOSM_INV_RESET;
         cap_ref_q <= `IOSM_CAPREF_RESET;
      end else if (wr_en) begin
         unique case (paddr)
            `IOSM_OFF_CTRL: begin
               comm_q <= pwdata[`IOSM_CTRL_COMM_BIT];
               scope_q <= pwdata[`IOSM_CTRL_SCOPE_LSB +: 2];
               view_q <= iosm_pkg::iosm_view_t'(pwdata[`IOSM_CTRL_VIEW_LSB +: 3]);
            end
            `IOSM_OFF_INV: inv_q <= pwdata[4:0];
            `IOSM_OFF_CAPREF: cap_ref_q <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   // read multiplexer and address decode
   always_comb begin
      rd_d = 32'h0000_0000;
      hit_d = 1'b1;
      unique case (paddr)
         `IOSM_OFF_CTRL: rd_d = {25'h0000000, view_q, 1'b0, scope_q, comm_q};
         `IOSM_OFF_INV: rd_d = {27'h0000000, inv_q};
         `IOSM_OFF_CAPREF: rd_d = {16'h0000, cap_ref_q};
         `IOSM_OFF_STAT_IN: rd_d = {16'h0000, in_status_q};
         `IOSM_OFF_STAT_OUT: rd_d = {16'h0000, out_status_q};
         `IOSM_OFF_HOURS: rd_d = {15'h0000, hours_shown};
         `IOSM_OFF_DCV: rd_d = {16'h0000, dcv_q};
         `IOSM_OFF_HEAT: rd_d = {16'h0000, heat_peak};
         `IOSM_OFF_CURR: rd_d = {16'h0000, curr_peak};
         `IOSM_OFF_CAPPCT: rd_d = {16'h0000, cap_pct_q};
         `IOSM_OFF_CAPHRS: rd_d = {16'h0000, cap_hours_q};
         `IOSM_OFF_DISP: rd_d = {16'h0000, led_digit3, led_digit2,
                                 led_digit1, led_digit0};
         default: hit_d = 1'b0;
      endcase
   end

   // answer captured in the first running cycle of a request, so a setup
   // cycle lost to a frozen block cannot hand back stale data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
         ans_q <= 1'b0;
      end else if (ce) begin
         ans_q <= psel && !(penable && ans_q);
         if (psel && !ans_q) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_d;
            pslverr <= ~hit_d;
         end
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   a_unused_bits: assert property (
      @(posedge pclk) disable iff (!presetn)
      in_status_q[12:5] == 8'h00 && out_status_q[15:9] == 7'h00
      && out_status_q[7:1] == 7'h00)
      else $error("unassigned status bit set");

   a_link_bits_gate: assert property (
      @(posedge pclk) disable iff (!presetn)
      (ce && !comm_q) |=> in_status_q[15:13] == 3'h0)
      else $error("link bits shown outside link control");

   a_relay_bit: assert property (
      @(posedge pclk) disable iff (!presetn)
      (ce && relay_contact_output && !transistor_output)
      |=> out_status_q == 16'h0100)
      else $error("relay state not in bit 8");

   a_hours_wrap: assert property (
      @(posedge pclk) disable iff (!presetn)
      (ce && hour_tick && hours_q == 16'hffff) |=> hours_q == 16'h0000)
      else $error("hour count did not wrap to zero");

   a_hours_range: assert property (
      @(posedge pclk) disable iff (!presetn)
      hours_shown[16] ? (hours_shown[15:0] >= 16'd1000 && hours_shown[15:0] <= 16'd6553)
                      : hours_shown[15:0] < 16'd10000)
      else $error("hour display outside its range");

   a_cap_saturate: assert property (
      @(posedge pclk) disable iff (!presetn)
      cap_hours_q <= 16'd9999)
      else $error("capacitor hours past 99.99");

   a_cap_gate: assert property (
      @(posedge pclk) disable iff (!presetn)
      (!cap_on_q) |=> $stable(cap_sec_q) && $stable(cap_hours_q))
      else $error("capacitor time counted without voltage");

   a_menu_gate: assert property (
      @(posedge pclk) disable iff (!presetn)
      (ce && scope_q != 2'h2)
      |=> {led_digit3, led_digit2, led_digit1, led_digit0} == 16'h0000)
      else $error("view shown outside full menu");

   a_cap_full: assert property (
      @(posedge pclk) disable iff (!presetn)
      (ce && meas_valid && cap_ref_q != 16'h0000 && cap_meas == cap_ref_q)
      |=> cap_pct_q == 16'd100)
      else $error("shipment capacitance not one hundred percent");

endmodule : iosm_top

/* rtl/iosm_consts.svh */
// constants of the i/o status and maintenance monitor
// assumes inclusion by bare name from the rtl folder
`ifndef IOSM_CONSTS_SVH
`define IOSM_CONSTS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define IOSM_OFF_CTRL 8'h00
`define IOSM_OFF_INV 8'h04
`define IOSM_OFF_CAPREF 8'h08
`define IOSM_OFF_STAT_IN 8'h10
`define IOSM_OFF_STAT_OUT 8'h14
`define IOSM_OFF_HOURS 8'h18
`define IOSM_OFF_DCV 8'h1c
`define IOSM_OFF_HEAT 8'h20
`define IOSM_OFF_CURR 8'h24
`define IOSM_OFF_CAPPCT 8'h28
`define IOSM_OFF_CAPHRS 8'h2c
`define IOSM_OFF_DISP 8'h30

// ----------------------------------------
// control fields and reset values
// ----------------------------------------
`define IOSM_CTRL_COMM_BIT 0
`define IOSM_CTRL_SCOPE_LSB 1
`define IOSM_CTRL_VIEW_LSB 4
`define IOSM_CTRL_RESET 32'h0000_0000
`define IOSM_INV_RESET 5'h00
`define IOSM_CAPREF_RESET 16'h0000
`define IOSM_SCOPE_FULL 2'h2

// ----------------------------------------
// status word bit positions
// ----------------------------------------
`define IOSM_IN_LINK_FWD 13
`define IOSM_IN_LINK_REV 14
`define IOSM_IN_LINK_RST 15
`define IOSM_OUT_RELAY_BIT 8
`define IOSM_HOURS_RES_BIT 16

// ----------------------------------------
// timing and counting limits
// ----------------------------------------
`define IOSM_SEC_NS 1000000000
`define IOSM_CLK_NS 10
`define IOSM_HOUR_S 3600
`define IOSM_CAP_STEP_H 10
`define IOSM_HRS_FINE_LIMIT 16'h2710
`define IOSM_HRS_DIV 16'h000a
`define IOSM_CAP_SAT 16'h270f
`define IOSM_PCT_FULL 32'h0000_0064

`endif

/* rtl/iosm_pkg.sv */
// types shared by the i/o status and maintenance monitor
// assumes the constants header sits beside it
package iosm_pkg;

   // display view chosen by software
   typedef enum logic [2:0] {
      VIEW_IN, VIEW_OUT, VIEW_HRS, VIEW_DCV,
      VIEW_HEAT, VIEW_CURR, VIEW_CAPPCT, VIEW_CAPHRS
   } iosm_view_t;

   typedef logic [15:0] iosm_word_t;

endpackage : iosm_pkg

/* rtl/iosm_hex_digits.sv */
// splits a 16-bit word into four display nibbles
// assumes one clock, async active-low reset, ce freezes state
module iosm_hex_digits (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input wire logic ce, // clock enable
   input wire iosm_pkg::iosm_word_t word, // word to show
   output logic [3:0] digit3, // leftmost digit, bits 15:12
   output logic [3:0] digit2, // bits 11:8
   output logic [3:0] digit1, // bits 7:4
   output logic [3:0] digit0 // rightmost digit, bits 3:0
);

   // ----------------------------------------
   // nibble registers
   // ----------------------------------------
   // most significant nibble lands on the leftmost digit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         digit3 <= 4'h0;
         digit2 <= 4'h0;
         digit1 <= 4'h0;
         digit0 <= 4'h0;
      end else if (ce) begin
         digit3 <= word[15:12];
         digit2 <= word[11:8];
         digit1 <= word[7:4];
         digit0 <= word[3:0];
      end
   end

endmodule : iosm_hex_digits

/* rtl/iosm_peak_hold.sv */
// hourly peak tracker for one measured quantity
// assumes hour_start is a one-cycle pulse on the same clock
module iosm_peak_hold (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input wire logic ce, // clock enable
   input wire logic hour_start, // pulse: a new hour begins
   input wire logic sample_valid, // pulse: sample is fresh
   input wire iosm_pkg::iosm_word_t sample, // measured value
   output iosm_pkg::iosm_word_t peak // peak of the current hour
);

   logic fresh_q;

   // ----------------------------------------
   // peak register
   // ----------------------------------------
   // a sample arriving with hour_start is the first of the new hour
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fresh_q <= 1'b1;
         peak <= 16'h0000;
      end else if (ce) begin
         if (hour_start) begin
            fresh_q <= ~sample_valid;
            peak <= sample_valid ? sample : 16'h0000;
         end else if (sample_valid && (fresh_q || sample > peak)) begin
            fresh_q <= 1'b0;
            peak <= sample;
         end
      end
   end

   a_peak_first: assert property (
      @(posedge pclk) disable iff (!presetn)
      (ce && sample_valid && !hour_start && fresh_q)
      |=> peak == $past(sample))
      else $error("first sample of the hour not loaded");

endmodule : iosm_peak_hold

/* tb/iosm_far_side.sv */
// far side model: terminal contacts and common jumper of the monitor
// assumes the bench changes contact states just after a rising edge
module iosm_far_side (
   input wire logic [4:0] shorted, // contacts closed to common
   input wire logic src_mode, // jumper set to source
   output logic [4:0] pin, // terminal pin levels
   output logic src_pin // jumper pin
);
   timeunit 1ns;
   timeprecision 1ps;
   // sink pulls a closed pin low, source lifts it high; open pins take the other level
   assign pin = src_mode ? shorted : ~shorted;
   assign src_pin = src_mode;
endmodule : iosm_far_side

/* tb/tb.sv */
// self-checking bench for the i/o status and maintenance monitor
// assumes zero-wait apb answers while ce is high; short hour for speed
`include "iosm_consts.svh"

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, view_active;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, h0;
   logic [4:0] shorted, pin;
   logic src_mode, src_pin, lk_f, lk_r, lk_x, tr_out, rel_out, meas_valid, cap_on;
   logic [15:0] heat, curr, dcv, capm;
   logic [3:0] d3, d2, d1, d0;
   logic [1:0] oo;
   logic ce;
   int miscompares = 0;
   int num_checks = 0;
   int cycles = 0;

   // hour = 20 * 3 = 60 cycles, capacitor step = 600 cycles
   iosm_top #(.SEC_CYCLES(20), .HOUR_SECS(12'h003)) u_iosm_top (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .forward_run_input(pin[0]), .reverse_run_input(pin[1]),
      .general_input_1(pin[2]), .general_input_2(pin[3]), .general_input_3(pin[4]),
      .source_input_common(src_pin), .link_forward_command(lk_f),
      .link_reverse_command(lk_r), .link_reset_command(lk_x), .transistor_output(tr_out),
      .relay_contact_output(rel_out), .meas_valid(meas_valid), .heat_sink_temp(heat),
      .eff_current(curr), .dc_link_volts(dcv), .cap_meas(capm), .cap_voltage_on(cap_on),
      .view_active(view_active), .led_digit3(d3), .led_digit2(d2), .led_digit1(d1),
      .led_digit0(d0));

   iosm_far_side u_iosm_far_side (.shorted(shorted), .src_mode(src_mode), .pin(pin),
      .src_pin(src_pin));

   // ----------------------------------------
   // clock, timeout and shared tasks
   // ----------------------------------------
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // a hang counts as a mismatch and ends the run
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         close_out();
      end
   end

   task automatic close_out();
      if (miscompares == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : close_out

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask : tick

   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // only the bench timeout ends a wait that never sees pready
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // one measurement pulse, then an idle edge before the next
   task automatic sample(input logic [15:0] h, input logic [15:0] c);
      heat <= h;
      curr <= c;
      meas_valid <= 1'b1;
      @(posedge pclk);
      meas_valid <= 1'b0;
      @(posedge pclk);
   endtask : sample

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_inputs();
      logic [4:0] pats [2];
      pats = '{5'h05, 5'h1a};
      lk_f <= 1'b1;
      lk_r <= 1'b1;
      lk_x <= 1'b1;
      apb(1'b0, `IOSM_OFF_CTRL, 32'h0);
      chk(rd, `IOSM_CTRL_RESET);
      chk(view_active, 1'b0);
      // link commands high but no link control: top bits must stay clear
      for (int m = 0; m < 4; m++) begin
         src_mode <= m[1];
         shorted <= pats[m[0]];
         tick(5);
         apb(1'b0, `IOSM_OFF_STAT_IN, 32'h0);
         chk(rd, {27'h0, pats[m[0]]});
      end
   endtask : t_inputs

   task automatic t_link();
      // inversion set everywhere must not show under link control
      apb(1'b1, `IOSM_OFF_INV, 32'h1f);
      apb(1'b1, `IOSM_OFF_CTRL, 32'h5);
      shorted <= 5'h15;
      tick(5);
      apb(1'b0, `IOSM_OFF_STAT_IN, 32'h0);
      chk(rd, 32'he015);
      chk({16'h0, d3, d2, d1, d0}, 32'he015);
      chk(view_active, 1'b1);
      apb(1'b1, `IOSM_OFF_CTRL, 32'h1);
      tick(2);
      chk({d3, d2, d1, d0, 15'h0, view_active}, 32'h0);
      apb(1'b1, `IOSM_OFF_INV, 32'h0);
   endtask : t_link

   task automatic t_outputs();
      for (int i = 0; i < 4; i++) begin
         oo = i[1:0];
         tr_out <= oo[0];
         rel_out <= oo[1];
         tick(2);
         apb(1'b0, `IOSM_OFF_STAT_OUT, 32'h0);
         chk(rd, {23'h0, oo[1], 7'h0, oo[0]});
      end
      apb(1'b0, 8'h0c, 32'h0);
      chk({31'h0, pslverr}, 32'h1);
      chk(rd, 32'h0);
   endtask : t_outputs

   task automatic t_meas();
      apb(1'b1, `IOSM_OFF_CAPREF, 32'hc8);
      dcv <= 16'h0136;
      capm <= 16'h0032;
      // find an hour boundary so the peaks below fall in one hour
      apb(1'b0, `IOSM_OFF_HOURS, 32'h0);
      h0 = rd;
      for (int n = 0; n < 40 && rd === h0; n++) apb(1'b0, `IOSM_OFF_HOURS, 32'h0);
      chk(rd, h0 + 32'h1);
      sample(16'h0005, 16'h0007);
      sample(16'h0009, 16'h0002);
      sample(16'h0003, 16'h0006);
      apb(1'b0, `IOSM_OFF_HEAT, 32'h0);
      chk(rd, 32'h9);
      apb(1'b0, `IOSM_OFF_CURR, 32'h0);
      chk(rd, 32'h7);
      apb(1'b0, `IOSM_OFF_DCV, 32'h0);
      chk(rd, 32'h136);
      apb(1'b0, `IOSM_OFF_CAPPCT, 32'h0);
      chk(rd, 32'h19);
      tick(60);
      apb(1'b0, `IOSM_OFF_HEAT, 32'h0);
      chk(rd, 32'h0);
      sample(16'h0004, 16'h0001);
      apb(1'b0, `IOSM_OFF_HEAT, 32'h0);
      chk(rd, 32'h4);
   endtask : t_meas

   task automatic t_cap();
      // reads 600 cycles apart span exactly one ten-hour step while powered
      cap_on <= 1'b1;
      tick(25);
      apb(1'b0, `IOSM_OFF_CAPHRS, 32'h0);
      h0 = rd;
      tick(597);
      apb(1'b0, `IOSM_OFF_CAPHRS, 32'h0);
      chk(rd, h0 + 32'h1);
      cap_on <= 1'b0;
      tick(25);
      apb(1'b0, `IOSM_OFF_CAPHRS, 32'h0);
      h0 = rd;
      tick(1197);
      apb(1'b0, `IOSM_OFF_CAPHRS, 32'h0);
      chk(rd, h0);
   endtask : t_cap

   task automatic t_freeze();
      // a frozen block stalls the bus and keeps the word it held
      ce <= 1'b0;
      tr_out <= 1'b0;
      rel_out <= 1'b0;
      fork
         apb(1'b0, `IOSM_OFF_STAT_OUT, 32'h0);
         begin
            tick(4);
            chk(pready, 1'b0);
            ce <= 1'b1;
         end
      join
      chk(rd, 32'h101);
      apb(1'b0, `IOSM_OFF_STAT_OUT, 32'h0);
      chk(rd, 32'h0);
   endtask : t_freeze

   initial begin
      presetn = 1'b0;
      ce = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {shorted, src_mode, lk_f, lk_r, lk_x, tr_out, rel_out, meas_valid, cap_on} = '0;
      {heat, curr, dcv, capm} = '0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_inputs();
      t_link();
      t_outputs();
      t_freeze();
      t_meas();
      t_cap();
      close_out();
   end
endmodule : tb
